/* File: verilog/fes_defs.svh */
// Constants for the flash erase and suspend/resume sequencer.
`ifndef FES_DEFS_SVH
`define FES_DEFS_SVH
`define FES_OP_WREN 8'h06
`define FES_OP_WRDI 8'h04
`define FES_OP_RDSR1 8'h05
`define FES_OP_RDSR2 8'h35
`define FES_OP_BLKERASE 8'hD8
`define FES_OP_CHIP_A 8'hC7
`define FES_OP_CHIP_B 8'h60
`define FES_OP_SUSPEND 8'h75
`define FES_OP_RESUME 8'h7A
`define FES_OP_WRSR 8'h01
`define FES_OP_SECERASE 8'h20
`define FES_OP_SRERASE 8'h44
`define FES_OP_SRPROG 8'h42
`define FES_OP_PROG 8'h02
`define FES_OP_QPROG 8'h32
`define FES_OP_READ 8'h03
`define FES_OP_FREAD 8'h0B
`define FES_OP_DREAD 8'h3B
`define FES_OP_QREAD 8'h6B
`define FES_OP_DIOREAD 8'hBB
`define FES_OP_QIOREAD 8'hEB
`define FES_OP_MODERST 8'hFF
`define FES_BITS_OPCODE 6'd8
`define FES_BITS_ADDRCMD 6'd32
`define FES_TOP_BLOCK 7'h7F
`define FES_ALL_BLOCKS 8'h80
`define FES_BP_ALL 3'h7
`define FES_ADDR_PROT 4'h0
`define FES_ADDR_STATUS 4'h4
`define FES_PROT_RESET 6'h00
`define FES_RESP_OKAY 2'h0
`define FES_RESP_SLVERR 2'h2
`define FES_CLK_PERIOD_NS 10
`define FES_RESUME_BUSY_NS 200
`define FES_RESUME_BUSY_CYCLES \
   (`FES_RESUME_BUSY_NS / `FES_CLK_PERIOD_NS)
`define FES_BLOCK_ERASE_CYCLES 15000000
`define FES_CHIP_ERASE_CYCLES 400000000
`define FES_SUSPEND_LAT_CYCLES 2000
`endif

/* File: verilog/fes_pkg.sv */
// Types shared by the flash erase and suspend/resume sequencer.
package fes_pkg;
   // Serial pins after the pad, all asynchronous to mclk.
   typedef struct packed {
      logic selectN;
      logic sclk;
      logic si;
   } fes_spi_t;
   // Protection settings held in the protection register.
   typedef struct packed {
      logic complement;
      logic granule;
      logic fromBottom;
      logic [2:0] rangeBits;
   } fes_prot_t;
   // Erase order towards the array, one-cycle valid.
   typedef struct packed {
      logic valid;
      logic chip;
      logic [23:0] base;
   } fes_erase_t;
   // State of the page program sequencer that shares the pins.
   typedef struct packed {
      logic suspended;
      logic [6:0] block;
   } fes_prog_t;
   // Forwarded opcode for the read and program sequencers.
   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
   } fes_fwd_t;
   typedef enum logic [2:0] {
      FES_IDLE = 3'b000,
      FES_BLOCK = 3'b001,
      FES_CHIP = 3'b010,
      FES_SUSPENDING = 3'b011,
      FES_SUSPENDED = 3'b100
   } fes_state_t;
endpackage

/* File: verilog/fes_erase_sequencer.sv */
// Erase, suspend and resume sequencer behind the serial flash pins.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "fes_defs.svh"
module fes_erase_sequencer #(
   parameter int unsigned BLOCK_ERASE_CYCLES = `FES_BLOCK_ERASE_CYCLES,
   parameter int unsigned CHIP_ERASE_CYCLES = `FES_CHIP_ERASE_CYCLES,
   parameter int unsigned SUSPEND_LAT_CYCLES = `FES_SUSPEND_LAT_CYCLES
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Serial pins.
   input wire fes_pkg::fes_spi_t spiPins,
   output logic so,
   output logic soOe,
   // Page program sequencer state and command forwarding.
   input wire fes_pkg::fes_prog_t progState,
   output fes_pkg::fes_fwd_t fwdCmd,
   // Erase orders to the array.
   output fes_pkg::fes_erase_t eraseCmd,
   output logic busy,
   // AXI4-Lite write channels.
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import fes_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Decoding functions.

   // True when the 64 kB block is covered by the protection settings.
   function automatic logic blockProt(input logic [6:0] blk,
                                      input fes_prot_t p);
      logic edgeBlk;
      logic inRange;
      logic partial;
      logic [7:0] span;
      begin
         span = 8'h01 << p.rangeBits;
         edgeBlk = p.fromBottom ? (blk == 7'h00) : (blk == `FES_TOP_BLOCK);
         if (p.rangeBits == 3'h0) begin
            inRange = 1'b0;
         end else if (p.rangeBits == `FES_BP_ALL) begin
            inRange = 1'b1;
         end else if (p.granule) begin
            inRange = edgeBlk;
         end else if (p.fromBottom) begin
            inRange = {1'b0, blk} < span;
         end else begin
            inRange = {1'b0, blk} >= (`FES_ALL_BLOCKS - span);
         end
         // A sector-grain range only covers part of its edge block.
         partial = p.granule && edgeBlk && (p.rangeBits != 3'h0) &&
                   (p.rangeBits != `FES_BP_ALL);
         return p.complement ? (!inRange || partial) : inRange;
      end
   endfunction

   // True when an opcode may run while an operation is paused.
   function automatic logic allowedPaused(input logic [7:0] op,
                                          input logic progPaused);
      begin
         case (op)
            `FES_OP_READ, `FES_OP_FREAD, `FES_OP_DREAD, `FES_OP_QREAD,
            `FES_OP_DIOREAD, `FES_OP_QIOREAD: begin
               return 1'b1;
            end
            `FES_OP_MODERST, `FES_OP_RDSR1, `FES_OP_RDSR2, `FES_OP_WREN,
            `FES_OP_RESUME: begin
               return 1'b1;
            end
            `FES_OP_PROG: begin
               return !progPaused;
            end
            `FES_OP_SECERASE, `FES_OP_BLKERASE: begin
               return progPaused;
            end
            default: begin
               // Status write, security ops, quad program, chip erase.
               return 1'b0;
            end
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection.

   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;
   logic sclkPrev_reg;
   logic selPrev_reg;
   logic selN;
   logic sclkRise;
   logic sclkFall;
   logic selRise;

   // Two flops per pin; only the second stage is looked at.
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinMeta_reg <= 3'h7;
         pinSync_reg <= 3'h7;
         sclkPrev_reg <= 1'b1;
         selPrev_reg <= 1'b1;
      end else begin
         pinMeta_reg <= spiPins;
         pinSync_reg <= pinMeta_reg;
         sclkPrev_reg <= pinSync_reg[1];
         selPrev_reg <= pinSync_reg[2];
      end
   end

   assign selN = pinSync_reg[2];
   assign sclkRise = pinSync_reg[1] && !sclkPrev_reg && !selN;
   assign sclkFall = !pinSync_reg[1] && sclkPrev_reg && !selN;
   assign selRise = selN && !selPrev_reg;

   ////////////////////////////////////////////////////////////////////////
   // Bit shifter, bit counter and opcode capture.

   logic [31:0] shift_reg;
   logic [5:0] bitCnt_reg;
   logic [7:0] opcode_reg;
   logic [7:0] opcodeNow;
   logic opcodeDone;

   assign opcodeNow = {shift_reg[6:0], pinSync_reg[0]};
   assign opcodeDone = sclkRise && (bitCnt_reg == `FES_BITS_OPCODE - 6'd1);

   // The count saturates so a long frame never looks like a short one.
   always_ff @(posedge mclk) begin
      if (rst || selN) begin
         bitCnt_reg <= 6'h00;
      end else if (sclkRise && bitCnt_reg != 6'h3F) begin
         bitCnt_reg <= bitCnt_reg + 6'd1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         shift_reg <= 32'h0000_0000;
         opcode_reg <= 8'h00;
      end else if (sclkRise) begin
         shift_reg <= {shift_reg[30:0], pinSync_reg[0]};
         if (opcodeDone) begin
            opcode_reg <= opcodeNow;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decision at the rise of select.

   fes_state_t state_reg;
   fes_prot_t prot_reg;
   logic latch_reg;
   logic susp_reg;
   logic paused;
   logic busyNow;
   logic opOnly;
   logic addrOnly;
   logic [6:0] blkAddr;
   logic blkPausedOk;
   logic startBlock;
   logic startChip;
   logic takeSuspend;
   logic takeResume;
   logic doneOp;

   assign busyNow = (state_reg == FES_BLOCK) || (state_reg == FES_CHIP) ||
                    (state_reg == FES_SUSPENDING);
   assign paused = susp_reg || progState.suspended;
   assign opOnly = bitCnt_reg == `FES_BITS_OPCODE;
   assign addrOnly = bitCnt_reg == `FES_BITS_ADDRCMD;
   // Low sixteen address bits select nothing within the block.
   assign blkAddr = shift_reg[22:16];
   // A paused program keeps its block out of reach of a new erase.
   assign blkPausedOk = !paused ||
      (allowedPaused(`FES_OP_BLKERASE, progState.suspended) && !susp_reg &&
       blkAddr != progState.block);

   assign startBlock = selRise && opcode_reg == `FES_OP_BLKERASE &&
      addrOnly && latch_reg && !busyNow && blkPausedOk &&
      !blockProt(blkAddr, prot_reg);
   assign startChip = selRise && opOnly && latch_reg && !busyNow &&
      !paused && (opcode_reg == `FES_OP_CHIP_A ||
      opcode_reg == `FES_OP_CHIP_B) && (prot_reg.complement ?
      prot_reg.rangeBits == `FES_BP_ALL :
      prot_reg.rangeBits == 3'h0);
   // Only a running block erase can be paused here; chip erase cannot.
   // A program already paused shows in the flag, so a second pause is ignored.
   assign takeSuspend = selRise && opOnly &&
      opcode_reg == `FES_OP_SUSPEND && !paused && busyNow &&
      state_reg == FES_BLOCK;
   assign takeResume = selRise && opOnly && opcode_reg == `FES_OP_RESUME &&
      susp_reg && !busyNow;

   ////////////////////////////////////////////////////////////////////////
   // Operation state machine and timers.

   logic [31:0] remain_reg;
   logic [31:0] latCnt_reg;
   logic [23:0] target_reg;

   // A suspend in the last cycle wins; the erase then ends after resume.
   assign doneOp = (state_reg == FES_BLOCK || state_reg == FES_CHIP) &&
                   remain_reg == 32'h0000_0001 && !takeSuspend;

   // The remaining erase time survives a pause so resume picks it up.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= FES_IDLE;
         remain_reg <= 32'h0000_0000;
         latCnt_reg <= 32'h0000_0000;
         target_reg <= 24'h00_0000;
      end else begin
         case (state_reg)
            FES_IDLE: begin
               if (startBlock) begin
                  state_reg <= FES_BLOCK;
                  remain_reg <= BLOCK_ERASE_CYCLES;
                  target_reg <= {1'b0, blkAddr, 16'h0000};
               end else if (startChip) begin
                  state_reg <= FES_CHIP;
                  remain_reg <= CHIP_ERASE_CYCLES;
                  target_reg <= 24'h00_0000;
               end
            end
            FES_BLOCK, FES_CHIP: begin
               if (takeSuspend) begin
                  state_reg <= FES_SUSPENDING;
                  latCnt_reg <= 32'h0000_0001;
               end else if (doneOp) begin
                  state_reg <= FES_IDLE;
               end else begin
                  remain_reg <= remain_reg - 32'd1;
               end
            end
            FES_SUSPENDING: begin
               // Busy falls once the suspend latency has run out.
               if (latCnt_reg >= SUSPEND_LAT_CYCLES) begin
                  state_reg <= FES_SUSPENDED;
               end else begin
                  latCnt_reg <= latCnt_reg + 32'd1;
               end
            end
            FES_SUSPENDED: begin
               if (takeResume) begin
                  state_reg <= FES_BLOCK;
               end
            end
            default: begin
               state_reg <= FES_IDLE;
            end
         endcase
      end
   end

   // Reset stands for power loss: any pause is forgotten.
   always_ff @(posedge mclk) begin
      if (rst) begin
         susp_reg <= 1'b0;
      end else if (takeSuspend) begin
         susp_reg <= 1'b1;
      end else if (takeResume) begin
         susp_reg <= 1'b0;
      end
   end

   // Write enable may be given while paused but not while busy.
   always_ff @(posedge mclk) begin
      if (rst) begin
         latch_reg <= 1'b0;
      end else if (doneOp) begin
         latch_reg <= 1'b0;
      end else if (selRise && opOnly && !busyNow) begin
         if (opcode_reg == `FES_OP_WREN) begin
            latch_reg <= 1'b1;
         end else if (opcode_reg == `FES_OP_WRDI) begin
            latch_reg <= 1'b0;
         end
      end
   end

   // The array is told to fill the range with FFh when the time is over.
   always_ff @(posedge mclk) begin
      if (rst) begin
         eraseCmd <= '0;
      end else begin
         eraseCmd.valid <= doneOp;
         eraseCmd.chip <= state_reg == FES_CHIP;
         eraseCmd.base <= target_reg;
      end
   end

   assign busy = busyNow;

   ////////////////////////////////////////////////////////////////////////
   // Status read-out and command forwarding.

   logic readOut_reg;
   logic readSr2_reg;
   logic [2:0] outIdx_reg;
   logic [7:0] statusByte;
   logic ownOp;

   // Status answers stay open while busy so the host can poll.
   assign statusByte = readSr2_reg ?
      {paused, prot_reg.complement, 6'h00} :
      {1'b0, prot_reg.granule, prot_reg.fromBottom, prot_reg.rangeBits,
       latch_reg, busyNow};

   always_ff @(posedge mclk) begin
      if (rst || selN) begin
         readOut_reg <= 1'b0;
         readSr2_reg <= 1'b0;
         outIdx_reg <= 3'h7;
         so <= 1'b0;
      end else if (opcodeDone && (opcodeNow == `FES_OP_RDSR1 ||
                   opcodeNow == `FES_OP_RDSR2)) begin
         readOut_reg <= 1'b1;
         readSr2_reg <= opcodeNow == `FES_OP_RDSR2;
         outIdx_reg <= 3'h7;
      end else if (sclkFall && readOut_reg) begin
         so <= statusByte[outIdx_reg];
         outIdx_reg <= outIdx_reg - 3'd1;
      end
   end

   assign soOe = readOut_reg && !selN;

   assign ownOp = opcodeNow == `FES_OP_WREN || opcodeNow == `FES_OP_WRDI ||
      opcodeNow == `FES_OP_RDSR1 || opcodeNow == `FES_OP_RDSR2 ||
      opcodeNow == `FES_OP_BLKERASE || opcodeNow == `FES_OP_CHIP_A ||
      opcodeNow == `FES_OP_CHIP_B || opcodeNow == `FES_OP_SUSPEND ||
      (opcodeNow == `FES_OP_RESUME && susp_reg);

   // Foreign opcodes go on only if the pause filter lets them through.
   always_ff @(posedge mclk) begin
      if (rst) begin
         fwdCmd <= '0;
      end else begin
         fwdCmd.valid <= opcodeDone && !ownOp &&
            (!paused || allowedPaused(opcodeNow, progState.suspended));
         fwdCmd.opcode <= opcodeNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: protection register and status register.

   logic awHeld_reg;
   logic wHeld_reg;
   logic [3:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;

   assign awready = !awHeld_reg;
   assign wready = !wHeld_reg;
   assign arready = !rvalid;

   // Address and data are held apart and answered once both are in.
   always_ff @(posedge mclk) begin
      if (rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 4'h0;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `FES_RESP_OKAY;
         prot_reg <= `FES_PROT_RESET;
      end else begin
         if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end else if (awHeld_reg && wHeld_reg && !bvalid) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (awAddr_reg == `FES_ADDR_PROT ||
                      awAddr_reg == `FES_ADDR_STATUS) ?
                     `FES_RESP_OKAY : `FES_RESP_SLVERR;
            if (awAddr_reg == `FES_ADDR_PROT && wStrb_reg[0]) begin
               prot_reg <= wData_reg[5:0];
            end
         end
      end
   end

   // Reads return live state one cycle after the address is taken.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `FES_RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= `FES_RESP_OKAY;
         if (araddr == `FES_ADDR_PROT) begin
            rdata <= {26'h000_0000, prot_reg};
         end else if (araddr == `FES_ADDR_STATUS) begin
            rdata <= {26'h000_0000, state_reg, paused, latch_reg, busyNow};
         end else begin
            rdata <= 32'h0000_0000;
            rresp <= `FES_RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence frameEnd32_s;
      selRise && addrOnly;
   endsequence
   sequence resumeRise_s;
      !susp_reg ##[1:20] busy;
   endsequence

   blockFrame_a: assert property (@(posedge mclk) disable iff (rst)
      startBlock |-> frameEnd32_s and (latch_reg && !busyNow))
      else $error("block erase began without a full frame or latch");
   blockProt_a: assert property (@(posedge mclk) disable iff (rst)
      startBlock |-> !blockProt(blkAddr, prot_reg))
      else $error("protected block was erased");
   eraseEnd_a: assert property (@(posedge mclk) disable iff (rst)
      doneOp |=> !busy && !latch_reg && eraseCmd.valid)
      else $error("erase end did not clear busy and latch");
   blockBusy_a: assert property (@(posedge mclk) disable iff (rst)
      startBlock |=> busy [*8])
      else $error("busy not held during block erase");
   suspendFlag_a: assert property (@(posedge mclk) disable iff (rst)
      takeSuspend |=> susp_reg && $stable(remain_reg))
      else $error("suspend flag not set at once");
   suspendLat_a: assert property (@(posedge mclk) disable iff (rst)
      state_reg == FES_SUSPENDING |-> latCnt_reg <= SUSPEND_LAT_CYCLES)
      else $error("busy outlasted suspend latency");
   chipNoSusp_a: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == FES_CHIP && !doneOp) |=> !susp_reg)
      else $error("chip erase was suspended");
   resumeBusy_a: assert property (@(posedge mclk) disable iff (rst)
      takeResume |=> resumeRise_s)
      else $error("resume did not raise busy in time");
   chipProt_a: assert property (@(posedge mclk) disable iff (rst)
      startChip |-> (prot_reg.complement ? prot_reg.rangeBits == 3'h7 :
                     prot_reg.rangeBits == 3'h0))
      else $error("chip erase started with protection set");
endmodule

/* File: verif/fes_spi_host.sv */
// Host serial controller model that frames commands to the sequencer.
`timescale 1ns/1ns
module fes_spi_host (
   // Serial pins.
   output fes_pkg::fes_spi_t spiPins,
   input wire logic so
);
   import fes_pkg::*;
   // Deselected with the clock low; the clock stands still between frames.
   initial spiPins = 3'b101;
   // Mode 0 frame of n bits, MSB first, select raised after the last bit.
   // So is sampled late in the high phase, well after the device moved it.
   task automatic frame(input logic [31:0] d, input logic [5:0] n,
      output logic [7:0] r);
      #3 spiPins.selectN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spiPins.si = d[i];
         #40 spiPins.sclk = 1'b1;
         #40 r = {r[6:0], so};
         spiPins.sclk = 1'b0;
      end
      #40 spiPins.selectN = 1'b1;
      // A released line must not keep showing the last bit.
      spiPins.si = ~spiPins.si;
      #80;
   endtask
endmodule

/* File: verif/test_flash_erase_suspend_resume.sv */
// Self-checking bench for the erase and suspend/resume sequencer.
`timescale 1ns/1ns
module test_flash_erase_suspend_resume;
   import fes_pkg::*;
   // Table row: protection, write enable first, frame, expected order.
   typedef struct packed {
      logic [5:0] prot;
      logic wren;
      logic [5:0] n;
      logic [31:0] cmd;
      logic go;
      logic [24:0] exp;
   } fes_row_t;
   fes_row_t rows [10];
   fes_spi_t spiPins;
   fes_erase_t eraseCmd;
   fes_fwd_t fwd;
   fes_prog_t prog = '0;
   int fwN = 0, f0;
   logic [7:0] fwLast = 8'h00;
   logic mclk = 1'b0, rst = 1'b1;
   logic so, busy, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, s;
   logic [1:0] bresp, rresp, r;
   logic [7:0] sr;
   logic [24:0] erLast = 25'h0;
   int erN = 0, n0, fails = 0, samples_checked = 0, cyc = 0;
   fes_erase_sequencer #(.BLOCK_ERASE_CYCLES(2000),
      .CHIP_ERASE_CYCLES(1000), .SUSPEND_LAT_CYCLES(10)) i_dut (
      .mclk(mclk), .rst(rst), .spiPins(spiPins), .so(so), .soOe(),
      .progState(prog), .fwdCmd(fwd), .eraseCmd(eraseCmd), .busy(busy),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   fes_spi_host i_host (.spiPins(spiPins), .so(so));
   always #5 mclk = ~mclk;
   // Count erase orders; a run past the ceiling counts as a mismatch.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (eraseCmd.valid) begin
         erN <= erN + 1;
         erLast <= {eraseCmd.chip, eraseCmd.base};
      end
      if (fwd.valid) begin
         fwN <= fwN + 1;
         fwLast <= fwd.opcode;
      end
      if (cyc == 90000) begin
         fails++;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] v, input logic [31:0] e);
      samples_checked++;
      if (v !== e) begin
         fails++;
         $display("BAD %0t %h %h", $time, v, e);
      end
   endtask
   // Write: address and data offered together, each dropped once taken.
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge mclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      while (pa || pw) begin
         @(posedge mclk);
         if (pa && awready) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && wready) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] q);
      @(posedge mclk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      d = rdata;
      q = rresp;
      rready <= 1'b0;
   endtask
   task st;
      rd(4'h4, s, r);
   endtask
   task idle;
      do st; while (s[0] !== 1'b0);
   endtask
   task finish_test;
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rows[0] = {6'h00, 1'b1, 6'h20, 32'hD8123456, 1'b1, 25'h0120000};
      rows[1] = {6'h00, 1'b0, 6'h20, 32'hD8123456, 1'b0, 25'h0};
      rows[2] = {6'h00, 1'b1, 6'h18, 32'h00D81234, 1'b0, 25'h0};
      rows[3] = {6'h07, 1'b1, 6'h20, 32'hD8000000, 1'b0, 25'h0};
      rows[4] = {6'h01, 1'b1, 6'h20, 32'hD87F0000, 1'b0, 25'h0};
      rows[5] = {6'h01, 1'b1, 6'h20, 32'hD8000000, 1'b1, 25'h0};
      rows[6] = {6'h00, 1'b1, 6'h08, 32'h000000C7, 1'b1, 25'h1000000};
      rows[7] = {6'h01, 1'b1, 6'h08, 32'h000000C7, 1'b0, 25'h0};
      rows[8] = {6'h00, 1'b1, 6'h10, 32'h0000C700, 1'b0, 25'h0};
      rows[9] = {6'h27, 1'b1, 6'h08, 32'h00000060, 1'b1, 25'h1000000};
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      // Reset state, an unmapped offset and protection readback.
      st;
      chk(s, 32'h0);
      rd(4'h8, s, r);
      chk(r, 2'h2);
      wr(4'h0, 32'h2A);
      rd(4'h0, s, r);
      chk(s, 32'h2A);
      // Each row: enable if the row asks for it, command, status read over the link, outcome.
      foreach (rows[i]) begin
         wr(4'h0, rows[i].prot);
         if (rows[i].wren) i_host.frame(32'h06, 6'h08, sr);
         n0 = erN;
         i_host.frame(rows[i].cmd, rows[i].n, sr);
         i_host.frame(32'h0500, 6'h10, sr);
         chk(sr[0], rows[i].go);
         idle;
         chk(erN - n0, rows[i].go);
         chk(s[1], rows[i].wren & ~rows[i].go);
         if (rows[i].go)
            chk({erLast[24], erLast[24] ? 24'h0 : erLast[23:0]},
               rows[i].exp);
      end
      // Erase pause: refusals while paused, then resume to the end.
      wr(4'h0, 32'h0);
      i_host.frame(32'h06, 6'h08, sr);
      n0 = erN;
      i_host.frame(32'hD8010000, 6'h20, sr);
      i_host.frame(32'h75, 6'h08, sr);
      st;
      chk(s[2], 1'b1);
      idle;
      chk({s[5:2], s[0]}, 5'h12);
      i_host.frame(32'h06, 6'h08, sr);
      i_host.frame(32'hD8200000, 6'h20, sr);
      i_host.frame(32'hD8010000, 6'h20, sr);
      i_host.frame(32'hC7, 6'h08, sr);
      i_host.frame(32'h75, 6'h08, sr);
      st;
      chk({s[5:2], s[0]}, 5'h12);
      i_host.frame(32'h7A, 6'h08, sr);
      st;
      chk({s[2], s[0]}, 2'h1);
      idle;
      chk(erN - n0, 1);
      chk(erLast, 25'h0010000);
      // Resume and suspend with nothing to act on are ignored.
      i_host.frame(32'h7A, 6'h08, sr);
      i_host.frame(32'h75, 6'h08, sr);
      st;
      chk(s[5:0], 6'h00);
      // A chip erase cannot be paused.
      i_host.frame(32'h06, 6'h08, sr);
      i_host.frame(32'hC7, 6'h08, sr);
      i_host.frame(32'h75, 6'h08, sr);
      st;
      chk({s[5:2], s[0]}, 5'h09);
      idle;
      // Program paused on block 1: programs and that block are refused.
      prog <= {1'b1, 7'h01};
      f0 = fwN;
      i_host.frame(32'h02, 6'h08, sr);
      i_host.frame(32'h03, 6'h08, sr);
      chk(fwN - f0, 1);
      chk(fwLast, 8'h03);
      n0 = erN;
      i_host.frame(32'h06, 6'h08, sr);
      i_host.frame(32'hD8010000, 6'h20, sr);
      st;
      chk(s[0], 1'b0);
      i_host.frame(32'hD8020000, 6'h20, sr);
      i_host.frame(32'h75, 6'h08, sr);
      st;
      chk({s[5:2], s[0]}, 5'h07);
      idle;
      chk(erN - n0, 1);
      chk(erLast, 25'h0020000);
      // Power loss while an erase is paused forgets the pause.
      prog <= '0;
      i_host.frame(32'h06, 6'h08, sr);
      i_host.frame(32'hD8010000, 6'h20, sr);
      i_host.frame(32'h75, 6'h08, sr);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      st;
      chk(s, 32'h0);
      finish_test;
   end
endmodule
